// *** dv/pcamc_top_tb.sv ***
// Self-checking testbench for the counter array compare block
`timescale 1ns/10ps
`default_nettype none
module pcamc_top_tb
  import pcamc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [2:0] module_output_pin;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rdat;
  logic rerr;

  pcamc_top #(.NUM_MOD(3)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .module_output_pin(module_output_pin)
  );

  always #20 pclk = ~pclk;

  task end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    err_total++;
    end_of_test();
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rd_chk(input string name, input logic [7:0] idx,
              input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rdat, exp);
    check("pslverr", {31'h0, rerr}, 32'h0000_0000);
  endtask

  // Counter is stopped first so the written value stays put
  task set_cnt(input logic [7:0] hi, input logic [7:0] lo);
    wr(PCAMC_IDX_CTRL, 8'h00);
    wr(PCAMC_IDX_CNT_LOW, lo);
    wr(PCAMC_IDX_CNT_HIGH, hi);
  endtask

  task settle();
    repeat (3) @(negedge pclk);
  endtask

  task t_reset();
    int m;
    rd_chk("cnt_low", PCAMC_IDX_CNT_LOW, 32'h0);
    rd_chk("cnt_high", PCAMC_IDX_CNT_HIGH, 32'h0);
    for (m = 0; m < 3; m++) begin
      rd_chk("cap_low", PCAMC_IDX_CAP_LOW[m], 32'h0);
      rd_chk("cap_high", PCAMC_IDX_CAP_HIGH[m], 32'h0);
      rd_chk("mode", PCAMC_IDX_MODE[m], 32'h0);
    end
  endtask

  task t_cap_bytes();
    int m;
    for (m = 0; m < 3; m++) begin
      wr(PCAMC_IDX_MODE[m], 8'h40);
      wr(PCAMC_IDX_CAP_LOW[m], 8'hA5);
      rd_chk("mode_after_low", PCAMC_IDX_MODE[m], 32'h00);
      wr(PCAMC_IDX_CAP_HIGH[m], 8'h5A);
      rd_chk("mode_after_high", PCAMC_IDX_MODE[m], 32'h40);
      rd_chk("cap_low", PCAMC_IDX_CAP_LOW[m], 32'hA5);
      rd_chk("cap_high", PCAMC_IDX_CAP_HIGH[m], 32'h5A);
    end
  endtask

  task t_reload();
    wr(PCAMC_IDX_CAP_LOW[0], 8'h11);
    wr(PCAMC_IDX_PWM_CTRL, 8'h80);
    wr(PCAMC_IDX_CAP_LOW[0], 8'h22);
    wr(PCAMC_IDX_CAP_HIGH[0], 8'h33);
    rd_chk("reload_low", PCAMC_IDX_CAP_LOW[0], 32'h22);
    rd_chk("reload_high", PCAMC_IDX_CAP_HIGH[0], 32'h33);
    wr(PCAMC_IDX_PWM_CTRL, 8'h00);
    rd_chk("cap_low_kept", PCAMC_IDX_CAP_LOW[0], 32'h11);
    rd_chk("cap_high_kept", PCAMC_IDX_CAP_HIGH[0], 32'h5A);
  endtask

  task t_counter();
    set_cnt(8'h12, 8'h34);
    rd_chk("cnt_low", PCAMC_IDX_CNT_LOW, 32'h34);
    rd_chk("cnt_high", PCAMC_IDX_CNT_HIGH, 32'h12);
    wr(PCAMC_IDX_CNT_HIGH, 8'h56);
    rd_chk("snap_stale", PCAMC_IDX_CNT_HIGH, 32'h12);
    rd_chk("cnt_low", PCAMC_IDX_CNT_LOW, 32'h34);
    rd_chk("snap_new", PCAMC_IDX_CNT_HIGH, 32'h56);
    wr(PCAMC_IDX_CTRL, 8'h02);
    wr(PCAMC_IDX_CNT_LOW, 8'hAA);
    wr(PCAMC_IDX_CNT_HIGH, 8'hBB);
    rd_chk("wdog_low", PCAMC_IDX_CNT_LOW, 32'h34);
    rd_chk("wdog_high", PCAMC_IDX_CNT_HIGH, 32'h56);
    wr(PCAMC_IDX_CTRL, 8'h00);
  endtask

  task t_match_irq();
    int i;
    set_cnt(8'h00, 8'h00);
    wr(PCAMC_IDX_CAP_LOW[0], 8'h10);
    wr(PCAMC_IDX_CAP_HIGH[0], 8'h00);
    wr(PCAMC_IDX_MODE[0], 8'h0D);
    wr(PCAMC_IDX_MASK, 8'h01);
    wr(PCAMC_IDX_STATUS, 8'h0F);
    wr(PCAMC_IDX_CTRL, 8'h01);
    repeat (40) @(posedge pclk);
    set_cnt(8'h00, 8'h00);
    rd_chk("status_no_comp", PCAMC_IDX_STATUS, 32'h0);
    check("pin_no_comp", {31'h0, module_output_pin[0]}, 32'h0);
    wr(PCAMC_IDX_MODE[0], 8'h4D);
    wr(PCAMC_IDX_CTRL, 8'h01);
    for (i = 0; i < 60 && irq !== 1'b1; i++) begin
      @(negedge pclk);
    end
    check("irq_on_match", {31'h0, irq}, 32'h1);
    if (irq !== 1'b1) end_of_test();
    wr(PCAMC_IDX_CTRL, 8'h00);
    settle();
    rd_chk("status_match", PCAMC_IDX_STATUS, 32'h1);
    check("pin_toggled", {31'h0, module_output_pin[0]}, 32'h1);
    wr(PCAMC_IDX_MODE[0], 8'h4C);
    settle();
    check("irq_enable_off", {31'h0, irq}, 32'h0);
    wr(PCAMC_IDX_MODE[0], 8'h4D);
    wr(PCAMC_IDX_MASK, 8'h00);
    settle();
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(PCAMC_IDX_MASK, 8'h01);
    settle();
    check("irq_unmasked", {31'h0, irq}, 32'h1);
    wr(PCAMC_IDX_STATUS, 8'h01);
    settle();
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rd_chk("status_cleared", PCAMC_IDX_STATUS, 32'h0);
  endtask

  // Duty 0x0530 tells the 16-bit compare from the 8-bit one
  task t_pwm();
    wr(PCAMC_IDX_CAP_LOW[1], 8'h30);
    wr(PCAMC_IDX_CAP_HIGH[1], 8'h05);
    wr(PCAMC_IDX_MODE[1], 8'hC2);
    set_cnt(8'h06, 8'h00);
    settle();
    check("pwm16_high", {31'h0, module_output_pin[1]}, 32'h1);
    set_cnt(8'h00, 8'h10);
    settle();
    check("pwm16_low", {31'h0, module_output_pin[1]}, 32'h0);
    wr(PCAMC_IDX_MODE[1], 8'h42);
    settle();
    check("pwm8_high", {31'h0, module_output_pin[1]}, 32'h1);
    set_cnt(8'h06, 8'h00);
    settle();
    check("pwm8_low", {31'h0, module_output_pin[1]}, 32'h0);
    // 10-bit duty 0x200 comes from the reload value, not the capture
    wr(PCAMC_IDX_PWM_CTRL, 8'h82);
    wr(PCAMC_IDX_CAP_LOW[1], 8'h00);
    wr(PCAMC_IDX_CAP_HIGH[1], 8'h02);
    wr(PCAMC_IDX_PWM_CTRL, 8'h02);
    set_cnt(8'h06, 8'h00);
    settle();
    check("pwm10_high", {31'h0, module_output_pin[1]}, 32'h1);
    set_cnt(8'h05, 8'h10);
    settle();
    check("pwm10_low", {31'h0, module_output_pin[1]}, 32'h0);
    wr(PCAMC_IDX_PWM_CTRL, 8'h00);
  endtask

  task count_toggles(input logic [7:0] mode, output int n);
    logic last;
    set_cnt(8'h00, 8'h00);
    wr(PCAMC_IDX_CAP_LOW[2], 8'h04);
    wr(PCAMC_IDX_CAP_HIGH[2], 8'h04);
    wr(PCAMC_IDX_MODE[2], mode);
    wr(PCAMC_IDX_CTRL, 8'h01);
    n = 0;
    last = module_output_pin[2];
    repeat (40) begin
      @(negedge pclk);
      if (module_output_pin[2] !== last) n++;
      last = module_output_pin[2];
    end
    wr(PCAMC_IDX_CTRL, 8'h00);
  endtask

  task t_freq();
    int n;
    count_toggles(8'h46, n);
    check("freq_toggles", {31'h0, n >= 8 && n <= 11}, 32'h1);
    count_toggles(8'h44, n);
    check("plain_toggles", n, 32'h0);
  endtask

  task t_unmapped();
    wr(8'h10, 8'hFF);
    check("wr_err", {31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h10, 8'h00);
    check("rd_err", {31'h0, rerr}, 32'h1);
    check("rd_zero", rdat, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cap_bytes();
    t_reload();
    t_counter();
    t_match_irq();
    t_pwm();
    t_freq();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** hw/pcamc_pkg.sv ***
// Package for the counter array compare modules and counter access block
package pcamc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] PCAMC_IDX_CNT_LOW = 8'hF9;
  localparam logic [7:0] PCAMC_IDX_CNT_HIGH = 8'hFA;
  localparam logic [2:0][7:0] PCAMC_IDX_CAP_LOW = {8'hEB, 8'hE9, 8'hFB};
  localparam logic [2:0][7:0] PCAMC_IDX_CAP_HIGH = {8'hEC, 8'hEA, 8'hFC};
  localparam logic [2:0][7:0] PCAMC_IDX_MODE = {8'hDC, 8'hDB, 8'hDA};
  localparam logic [7:0] PCAMC_IDX_PWM_CTRL = 8'hF7;
  localparam logic [7:0] PCAMC_IDX_CTRL = 8'hD8;
  localparam logic [7:0] PCAMC_IDX_STATUS = 8'hD9;
  localparam logic [7:0] PCAMC_IDX_MASK = 8'hDD;
  localparam int unsigned PCAMC_MAX_MOD = 3;
  // Field positions
  localparam int unsigned PCAMC_RELOAD_SEL_BIT = 7;
  localparam int unsigned PCAMC_RES_LSB = 0;
  localparam int unsigned PCAMC_RUN_BIT = 0;
  localparam int unsigned PCAMC_WDOG_BIT = 1;
  localparam int unsigned PCAMC_OVF_BIT = 3;
  // Reset values and counter top value
  localparam logic [7:0] PCAMC_RST_BYTE = 8'h00;
  localparam logic [15:0] PCAMC_RST_WORD = 16'h0000;
  localparam logic [31:0] PCAMC_RST_DATA = 32'h0000_0000;
  localparam logic [15:0] PCAMC_CNT_TOP = 16'hFFFF;

  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_enable;
    logic capt_pos_enable;
    logic capt_neg_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_mod_enable;
    logic flag_irq_enable;
  } pcamc_mode_t;

  typedef enum logic [1:0] {
    PCAMC_RES8 = 2'b00,
    PCAMC_RES9 = 2'b01,
    PCAMC_RES10 = 2'b10,
    PCAMC_RES11 = 2'b11
  } pcamc_res_t;
endpackage

// *** hw/pcamc_top.sv ***
// Counter array: compare modules, counter access and APB register slave
//
// Contract
// - PWM enable drives a modulated waveform onto the module output pin.
// - PWM resolution 8 to 11 bits when wide select clear, else 16 bits.
// - PWM enable plus toggle enable selects frequency output mode.
// - Interrupt request when flag set and its enable is 1; none if 0. Code also needs the flag's mask bit set.
// - Counter low byte register is bits 7:0, read/write, reset zero.
// - Counter high byte reads return a snapshot, not the live counter.
// - Snapshot loads from counter only when counter low byte is read.
// - Counter low byte writes are ignored while watchdog enable is 1.
// - Counter high byte writes are ignored while watchdog enable is 1.
// - Capture low byte holds compare bits 7:0, reset zero.
// - Capture low byte address can reach the reload low byte.
// - Reload select bit picks compare value or reload value access.
// - Writing capture low byte clears the comparator enable bit.
// - Writing capture high byte sets the comparator enable bit.
// - Capture high byte holds compare bits 15:8, aliased to reload.
`timescale 1ns/10ps
`default_nettype none
module pcamc_top
  import pcamc_pkg::*;
#(
  parameter int unsigned NUM_MOD = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [NUM_MOD-1:0] module_output_pin
);

  if (NUM_MOD < 1 || NUM_MOD > PCAMC_MAX_MOD) begin : g_bad_num
    $error("NUM_MOD must lie between 1 and 3");
  end

  logic [15:0] counter;
  logic [7:0] snapshot;
  logic [7:0] pulse_mod_control_reg;
  logic [7:0] ctrl;
  logic [7:0] status;
  logic [7:0] mask;
  logic [15:0] cap_val [NUM_MOD];
  logic [15:0] reload_val [NUM_MOD];
  pcamc_mode_t mode_reg [NUM_MOD];
  logic [NUM_MOD-1:0] pin_q;
  logic [NUM_MOD-1:0] cmp_hit;
  logic [NUM_MOD-1:0] freq_hit;
  logic [NUM_MOD-1:0] flag_set;
  logic [NUM_MOD-1:0] hit_cap_low;
  logic [NUM_MOD-1:0] hit_cap_high;
  logic [NUM_MOD-1:0] hit_mode;
  logic hit_cnt_low;
  logic hit_cnt_high;
  logic hit_pwm_ctrl;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] idx;
  logic addr_ok;
  logic xfer_done;
  logic wr_en;
  logic rd_acc;
  logic run;
  logic watchdog_enable;
  logic reload_select;
  pcamc_res_t res_sel;
  logic [15:0] res_mask;
  logic [7:0] irq_gate;
  logic ovf_event;

  assign module_output_pin = pin_q;
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  // Write lands at the completing edge; read data is sampled one edge
  // earlier, so the snapshot and the low byte come from one count value
  assign xfer_done = psel && penable && pready;
  assign wr_en = xfer_done && pwrite;
  assign rd_acc = psel && penable && !pready && !pwrite;
  assign run = ctrl[PCAMC_RUN_BIT];
  assign watchdog_enable = ctrl[PCAMC_WDOG_BIT];
  assign reload_select = pulse_mod_control_reg[PCAMC_RELOAD_SEL_BIT];
  assign res_sel = pcamc_res_t'(pulse_mod_control_reg[PCAMC_RES_LSB +: 2]);

  always_comb begin
    unique case (res_sel)
      PCAMC_RES8: res_mask = 16'h00FF;
      PCAMC_RES9: res_mask = 16'h01FF;
      PCAMC_RES10: res_mask = 16'h03FF;
      PCAMC_RES11: res_mask = 16'h07FF;
    endcase
  end

  // Address decode and read mux
  always_comb begin
    hit_cnt_low = addr_ok && (idx == PCAMC_IDX_CNT_LOW);
    hit_cnt_high = addr_ok && (idx == PCAMC_IDX_CNT_HIGH);
    hit_pwm_ctrl = addr_ok && (idx == PCAMC_IDX_PWM_CTRL);
    hit_ctrl = addr_ok && (idx == PCAMC_IDX_CTRL);
    hit_status = addr_ok && (idx == PCAMC_IDX_STATUS);
    hit_mask = addr_ok && (idx == PCAMC_IDX_MASK);
    mapped = hit_cnt_low || hit_cnt_high || hit_pwm_ctrl || hit_ctrl
             || hit_status || hit_mask;
    rd_byte = PCAMC_RST_BYTE;
    if (hit_cnt_low) rd_byte = counter[7:0];
    if (hit_cnt_high) rd_byte = snapshot;
    if (hit_pwm_ctrl) rd_byte = pulse_mod_control_reg;
    if (hit_ctrl) rd_byte = ctrl;
    if (hit_status) rd_byte = status;
    if (hit_mask) rd_byte = mask;
    for (int i = 0; i < NUM_MOD; i++) begin
      hit_cap_low[i] = addr_ok && (idx == PCAMC_IDX_CAP_LOW[i]);
      hit_cap_high[i] = addr_ok && (idx == PCAMC_IDX_CAP_HIGH[i]);
      hit_mode[i] = addr_ok && (idx == PCAMC_IDX_MODE[i]);
      mapped = mapped || hit_cap_low[i] || hit_cap_high[i] || hit_mode[i];
      if (hit_cap_low[i]) begin
        rd_byte = reload_select ? reload_val[i][7:0] : cap_val[i][7:0];
      end
      if (hit_cap_high[i]) begin
        rd_byte = reload_select ? reload_val[i][15:8] : cap_val[i][15:8];
      end
      if (hit_mode[i]) begin
        rd_byte = mode_reg[i];
      end
    end
  end

  // APB answer: one wait state, pready and data both from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PCAMC_RST_DATA;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        prdata <= pwrite ? PCAMC_RST_DATA : {24'h00_0000, rd_byte};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // 16-bit counter running while the run bit is set, with guarded software access
  assign ovf_event = run && (counter == PCAMC_CNT_TOP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= PCAMC_RST_WORD;
    end else if (wr_en && hit_cnt_low && !watchdog_enable) begin
      counter <= {counter[15:8], pwdata[7:0]};
    end else if (wr_en && hit_cnt_high && !watchdog_enable) begin
      counter <= {pwdata[7:0], counter[7:0]};
    end else if (run) begin
      counter <= counter + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot <= PCAMC_RST_BYTE;
    end else if (rd_acc && hit_cnt_low) begin
      snapshot <= counter[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_mod_control_reg <= PCAMC_RST_BYTE;
      ctrl <= PCAMC_RST_BYTE;
      mask <= PCAMC_RST_BYTE;
    end else if (wr_en) begin
      if (hit_pwm_ctrl) pulse_mod_control_reg <= pwdata[7:0];
      if (hit_ctrl) ctrl <= pwdata[7:0];
      if (hit_mask) mask <= pwdata[7:0];
    end
  end

  // Sticky status: hardware set wins over a write-one clear
  always_comb begin
    irq_gate = 8'h00;
    irq_gate[PCAMC_OVF_BIT] = 1'b1;
    for (int i = 0; i < NUM_MOD; i++) begin
      irq_gate[i] = mode_reg[i].flag_irq_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= PCAMC_RST_BYTE;
    end else begin
      status <= (status & ~((wr_en && hit_status) ? pwdata[7:0] : 8'h00))
                | {4'h0, ovf_event, 3'h0}
                | 8'(flag_set);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask & irq_gate);
    end
  end

  for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
    logic [15:0] duty;
    logic pwm_level;

    // Matching only runs with the comparator armed
    assign cmp_hit[g] = mode_reg[g].comparator_enable
                        && (counter == cap_val[g]);
    assign freq_hit[g] = mode_reg[g].comparator_enable
                         && (counter[7:0] == cap_val[g][7:0]);
    assign flag_set[g] = mode_reg[g].match_enable
                         && ((mode_reg[g].pulse_mod_enable
                              && mode_reg[g].toggle_enable)
                             ? freq_hit[g] : cmp_hit[g]);
    // 8-bit duty sits in the high capture byte; 9-11 bit use the reload
    assign duty = mode_reg[g].wide_pulse_select ? cap_val[g]
                  : (res_sel == PCAMC_RES8) ? {8'h00, cap_val[g][15:8]}
                  : (reload_val[g] & res_mask);
    assign pwm_level = mode_reg[g].wide_pulse_select ? (counter >= duty)
                       : ((counter & res_mask) >= duty);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_q[g] <= 1'b0;
      end else if (mode_reg[g].pulse_mod_enable
                   && mode_reg[g].toggle_enable) begin
        if (freq_hit[g]) begin
          pin_q[g] <= !pin_q[g];
        end
      end else if (mode_reg[g].pulse_mod_enable) begin
        pin_q[g] <= mode_reg[g].comparator_enable && pwm_level;
      end else if (mode_reg[g].toggle_enable && cmp_hit[g]) begin
        pin_q[g] <= !pin_q[g];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_reg[g] <= pcamc_mode_t'(PCAMC_RST_BYTE);
      end else if (wr_en && hit_cap_low[g]) begin
        mode_reg[g].comparator_enable <= 1'b0;
      end else if (wr_en && hit_cap_high[g]) begin
        mode_reg[g].comparator_enable <= 1'b1;
      end else if (wr_en && hit_mode[g]) begin
        mode_reg[g] <= pcamc_mode_t'(pwdata[7:0]);
      end
    end

    // Frequency mode steps the next edge by the high byte after a hit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cap_val[g] <= PCAMC_RST_WORD;
      end else if (wr_en && hit_cap_low[g] && !reload_select) begin
        cap_val[g][7:0] <= pwdata[7:0];
      end else if (wr_en && hit_cap_high[g] && !reload_select) begin
        cap_val[g][15:8] <= pwdata[7:0];
      end else if (mode_reg[g].pulse_mod_enable && mode_reg[g].toggle_enable
                   && freq_hit[g]) begin
        cap_val[g][7:0] <= cap_val[g][7:0] + cap_val[g][15:8];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        reload_val[g] <= PCAMC_RST_WORD;
      end else if (wr_en && hit_cap_low[g] && reload_select) begin
        reload_val[g][7:0] <= pwdata[7:0];
      end else if (wr_en && hit_cap_high[g] && reload_select) begin
        reload_val[g][15:8] <= pwdata[7:0];
      end
    end

    property p_low_clears_cmp;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_cap_low[g]) |=> !mode_reg[g].comparator_enable;
    endproperty
    a_low_clears_cmp: assert property (p_low_clears_cmp)
      else $error("capture low write left comparator enabled");

    property p_high_sets_cmp;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_cap_high[g]) |=> mode_reg[g].comparator_enable;
    endproperty
    a_high_sets_cmp: assert property (p_high_sets_cmp)
      else $error("capture high write left comparator disabled");

    property p_match_flag;
      @(posedge pclk) disable iff (!presetn)
      (cmp_hit[g] && mode_reg[g].match_enable
       && !mode_reg[g].pulse_mod_enable) |=> status[g];
    endproperty
    a_match_flag: assert property (p_match_flag)
      else $error("match did not set the module flag");

    property p_no_cmp_no_flag;
      @(posedge pclk) disable iff (!presetn)
      (!mode_reg[g].comparator_enable && !status[g]) |=> !status[g];
    endproperty
    a_no_cmp_no_flag: assert property (p_no_cmp_no_flag)
      else $error("flag set while comparator disabled");

    property p_toggle;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg[g].toggle_enable && !mode_reg[g].pulse_mod_enable
       && cmp_hit[g]) |=> (pin_q[g] != $past(pin_q[g]));
    endproperty
    a_toggle: assert property (p_toggle)
      else $error("output did not toggle on match");

    property p_freq;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg[g].toggle_enable && mode_reg[g].pulse_mod_enable
       && freq_hit[g]) |=> (pin_q[g] != $past(pin_q[g]));
    endproperty
    a_freq: assert property (p_freq)
      else $error("frequency output did not toggle");

    property p_pwm16;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg[g].pulse_mod_enable && !mode_reg[g].toggle_enable
       && mode_reg[g].wide_pulse_select && mode_reg[g].comparator_enable)
      |=> (pin_q[g] == ($past(counter) >= $past(cap_val[g])));
    endproperty
    a_pwm16: assert property (p_pwm16)
      else $error("16-bit pwm level wrong");

    property p_pwm8;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg[g].pulse_mod_enable && !mode_reg[g].toggle_enable
       && !mode_reg[g].wide_pulse_select && (res_sel == PCAMC_RES8)
       && mode_reg[g].comparator_enable)
      |=> (pin_q[g] == ($past(counter[7:0]) >= $past(cap_val[g][15:8])));
    endproperty
    a_pwm8: assert property (p_pwm8)
      else $error("8-bit pwm level wrong");

    property p_alias;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_cap_low[g] && reload_select
       && !mode_reg[g].pulse_mod_enable) |=> $stable(cap_val[g][7:0])
      && (reload_val[g][7:0] == $past(pwdata[7:0]));
    endproperty
    a_alias: assert property (p_alias)
      else $error("reload select did not steer capture write");
  end

  property p_snapshot;
    @(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_cnt_low) |=> (snapshot == $past(counter[15:8]));
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("snapshot not loaded on low byte read");

  property p_high_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_cnt_high) |=> (prdata[7:0] == $past(snapshot));
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte read did not return snapshot");

  property p_wdog_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && (hit_cnt_low || hit_cnt_high) && watchdog_enable && !run)
    |=> $stable(counter);
  endproperty
  a_wdog_lock: assert property (p_wdog_lock)
    else $error("counter changed under watchdog lock");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    ((status[0] && mask[0] && mode_reg[0].flag_irq_enable) |=> irq)
    and ((status[0] && mask[0] && !mode_reg[0].flag_irq_enable
          && (status & mask & 8'hFE) == 8'h00) |=> !irq);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow flag and enable");

endmodule
`default_nettype wire
